// *** core/tac_pkg.sv ***
// Constants for the conversion control, alarm and serial port block.
// Assumes one 10 MHz system clock; all timing counts derive from it.
package tac_pkg;

  // ---------------------------------------------------------------
  // Clock and conversion timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TEMP_NS = 27000;
  localparam int CONV_INPUT_NS = 9000;
  // Fixed durations round down, never below one cycle
  localparam int CONV_TEMP_CYC = (CONV_TEMP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 CONV_TEMP_NS / CLK_PERIOD_NS;
  localparam int CONV_INPUT_CYC = (CONV_INPUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  CONV_INPUT_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 9;

  // ---------------------------------------------------------------
  // Data widths and field layout
  // ---------------------------------------------------------------
  localparam int RESULT_W = 10;
  localparam int BYTE_W = 8;
  localparam int CHAN_W = 3;
  localparam int BIT_CNT_W = 4;
  localparam int CTRL_HI_MSB = 7;
  localparam int CTRL_HI_LSB = 3;
  localparam int ALARM_MSB = 9;
  localparam int ALARM_LSB = 2;

  // ---------------------------------------------------------------
  // Reset values and channel codes
  // ---------------------------------------------------------------
  localparam logic [CHAN_W-1:0] CHAN_TEMP = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [BYTE_W-1:0] THRESH_RESET = 8'h99;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

  typedef enum logic [0:0] {
    TAC_IDLE = 1'b0,
    TAC_CONVERT = 1'b1
  } tac_conv_state_t;

endpackage

// *** core/tac_top.sv ***
// Conversion control, over-temperature alarm and three-wire serial port.
// Assumes pin inputs are asynchronous to clk and the analog converter
// presents its code on sample_code in the clk domain when a conversion ends.
//
// Summary of operation
// - A falling edge of convert_start_n while idle starts one 10-bit conversion.
// - That falling edge switches the track/hold stage into hold.
// - Completion of the conversion puts the track/hold back into track.
// - convert_start_n is sampled at conversion end; low means power-down.
// - A temperature result above alarm_threshold_reg pulls over_temp_alarm_n low.
// - A rising edge of the read/write select releases the alarm high.
// - Data goes out on falling serial clock edges and comes in on rising ones.
// - One shared data pin carries both directions.
// - The channel address register chooses which input is converted.
// - A written byte with its five top bits zero loads the channel, else the threshold.
// - The alarm compares the top eight result bits with the threshold.
// - A temperature conversion finishes 27 us after the start edge.
module tac_top
  import tac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convert_start_n,
  input wire logic sclk,
  input wire logic rd_wr_sel,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  output logic over_temp_alarm_n,
  output logic track_hold,
  output logic power_down,
  output logic conv_active,
  output logic [tac_pkg::CHAN_W-1:0] channel_addr,
  output logic [tac_pkg::BYTE_W-1:0] alarm_threshold_reg,
  output logic [tac_pkg::RESULT_W-1:0] conv_result,
  input wire logic [tac_pkg::RESULT_W-1:0] sample_code
);
  import tac_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers and edge detection
  // ---------------------------------------------------------------
  // Order: 3 convert_start_n, 2 sclk, 1 rd_wr, 0 data
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
      sync_prev <= 4'hF;
    end else begin
      sync_a <= {convert_start_n, sclk, rd_wr_sel, data_in};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic rw_rise;
  logic rw_fall;
  assign cs_fall = sync_prev[3] & ~sync_b[3];
  assign cs_rise = ~sync_prev[3] & sync_b[3];
  assign sclk_rise = ~sync_prev[2] & sync_b[2];
  assign sclk_fall = sync_prev[2] & ~sync_b[2];
  assign rw_rise = ~sync_prev[1] & sync_b[1];
  assign rw_fall = sync_prev[1] & ~sync_b[1];

  function automatic logic [CONV_CNT_W-1:0] conv_len(input logic [CHAN_W-1:0] ch);
    if (ch == CHAN_TEMP)
      return CONV_CNT_W'(CONV_TEMP_CYC);
    return CONV_CNT_W'(CONV_INPUT_CYC);
  endfunction

  // ---------------------------------------------------------------
  // Conversion control and alarm
  // ---------------------------------------------------------------
  tac_conv_state_t state;
  tac_conv_state_t next_state;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic [CONV_CNT_W-1:0] next_conv_cnt;
  logic [CHAN_W-1:0] conv_chan;
  logic [CHAN_W-1:0] next_conv_chan;
  logic next_track_hold;
  logic next_power_down;
  logic next_alarm_n;
  logic [RESULT_W-1:0] next_result;
  logic conv_done;

  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_conv_chan = conv_chan;
    next_track_hold = track_hold;
    next_power_down = power_down;
    next_alarm_n = over_temp_alarm_n;
    next_result = conv_result;
    conv_done = 1'b0;
    // Release first so that a same-cycle alarm set below wins
    if (rw_rise)
      next_alarm_n = 1'b1;
    // Wake from power-down once the host lets convert_start_n go high
    if (cs_rise && state == TAC_IDLE)
      next_power_down = 1'b0;
    case (state)
      TAC_IDLE: begin
        if (cs_fall) begin
          next_state = TAC_CONVERT;
          next_track_hold = 1'b1;
          next_power_down = 1'b0;
          next_conv_chan = channel_addr;
          next_conv_cnt = conv_len(channel_addr) - CONV_CNT_W'(1);
        end
      end
      TAC_CONVERT: begin
        // Edges on convert_start_n during a conversion are ignored
        if (conv_cnt == '0) begin
          conv_done = 1'b1;
          next_state = TAC_IDLE;
          next_track_hold = 1'b0;
          next_result = sample_code;
          next_power_down = ~sync_b[3];
          if (conv_chan == CHAN_TEMP) begin
            if (sample_code[ALARM_MSB:ALARM_LSB] > alarm_threshold_reg)
              next_alarm_n = 1'b0;
            else if (sample_code[ALARM_MSB:ALARM_LSB] < alarm_threshold_reg)
              next_alarm_n = 1'b1;
          end
        end else begin
          next_conv_cnt = conv_cnt - CONV_CNT_W'(1);
        end
      end
      default: begin
        next_state = TAC_IDLE;
        next_track_hold = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= TAC_IDLE;
      conv_cnt <= '0;
      conv_chan <= CHAN_RESET;
      track_hold <= 1'b0;
      power_down <= 1'b0;
      over_temp_alarm_n <= 1'b1;
      conv_result <= RESULT_RESET;
      conv_active <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      conv_chan <= next_conv_chan;
      track_hold <= next_track_hold;
      power_down <= next_power_down;
      over_temp_alarm_n <= next_alarm_n;
      conv_result <= next_result;
      conv_active <= (next_state == TAC_CONVERT);
    end
  end

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  // Reads shift the last stored result, or the new one if the read starts in
  // the cycle a conversion ends; a conversion end during a read keeps the older word.
  logic [RESULT_W-1:0] out_shift;
  logic [RESULT_W-1:0] next_out_shift;
  logic [BYTE_W-1:0] in_shift;
  logic [BYTE_W-1:0] next_in_shift;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  logic [CHAN_W-1:0] next_channel;
  logic [BYTE_W-1:0] next_thresh;
  logic next_data_out;
  logic next_data_oe;
  logic [BYTE_W-1:0] byte_now;

  always_comb begin
    next_out_shift = out_shift;
    next_in_shift = in_shift;
    next_bit_cnt = bit_cnt;
    next_channel = channel_addr;
    next_thresh = alarm_threshold_reg;
    next_data_oe = sync_b[1];
    next_data_out = data_out;
    byte_now = {in_shift[BYTE_W-2:0], sync_b[0]};
    if (rw_rise) begin
      next_out_shift = conv_done ? next_result : conv_result;
      next_data_out = next_out_shift[RESULT_W-1];
      next_bit_cnt = '0;
    end else if (rw_fall) begin
      next_bit_cnt = '0;
      next_data_out = 1'b0;
    end else if (sync_b[1]) begin
      if (sclk_fall) begin
        next_out_shift = {out_shift[RESULT_W-2:0], 1'b0};
        next_data_out = out_shift[RESULT_W-2];
      end
    end else if (sclk_rise) begin
      next_in_shift = byte_now;
      if (bit_cnt == BIT_CNT_W'(BYTE_W - 1)) begin
        next_bit_cnt = '0;
        if (byte_now[CTRL_HI_MSB:CTRL_HI_LSB] == '0)
          next_channel = byte_now[CHAN_W-1:0];
        else
          next_thresh = byte_now;
      end else begin
        next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_shift <= RESULT_RESET;
      in_shift <= '0;
      bit_cnt <= '0;
      channel_addr <= CHAN_RESET;
      alarm_threshold_reg <= THRESH_RESET;
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      out_shift <= next_out_shift;
      in_shift <= next_in_shift;
      bit_cnt <= next_bit_cnt;
      channel_addr <= next_channel;
      alarm_threshold_reg <= next_thresh;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
    end
  end

endmodule

// *** tb/tac_top_props.sv ***
// Checker for the tac_top ports: conversion timing, alarm and serial pin.
// Assumes a bind onto tac_top; only its ports are seen.
module tac_top_props
  import tac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic rd_wr_sel,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic over_temp_alarm_n,
  input wire logic track_hold,
  input wire logic power_down,
  input wire logic conv_active,
  input wire logic [tac_pkg::CHAN_W-1:0] channel_addr,
  input wire logic [tac_pkg::BYTE_W-1:0] alarm_threshold_reg,
  input wire logic [tac_pkg::RESULT_W-1:0] conv_result
);
  // ----
  // Busy length counter; channel is frozen at the start
  // ----
  int cnt;
  logic lch;
  always_ff @(posedge clk) begin
    cnt <= (rst_n && conv_active) ? cnt + 1 : 0;
    if (!conv_active) begin
      lch <= (channel_addr == CHAN_TEMP);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_conv_len: assert property (
    $fell(conv_active) |-> cnt == (lch ? CONV_TEMP_CYC : CONV_INPUT_CYC)) else $error("busy length");
  a_hold_start: assert property ($rose(conv_active) |-> track_hold)
    else $error("no hold at start");
  a_track_end: assert property ($fell(conv_active) |-> $fell(track_hold))
    else $error("no track at end");
  a_pd_end: assert property ($rose(power_down) |-> $fell(conv_active))
    else $error("power-down off end");
  a_alarm_set: assert property (
    $fell(conv_active) && lch && conv_result[ALARM_MSB:ALARM_LSB] > alarm_threshold_reg
    |-> !over_temp_alarm_n) else $error("alarm not set");
  a_alarm_rel: assert property (
    $rose(over_temp_alarm_n) |-> $rose(data_oe) || $fell(conv_active)) else $error("alarm rel");
  a_oe_idle: assert property (!rd_wr_sel [*5] |-> !data_oe)
    else $error("pin driven outside read");
  a_out_fall: assert property ($changed(data_out) && data_oe && $past(data_oe) |-> !sclk)
    else $error("shift not on falling clock");
  a_reg_write: assert property (
    $changed(alarm_threshold_reg) || $changed(channel_addr) |-> !rd_wr_sel && sclk)
    else $error("register change outside write");
endmodule

// *** tb/tac_host.sv ***
// Host model on the three-wire serial port.
// Assumes the bench resolves the shared pin from both enables.
module tac_host (
  input wire logic clk,
  input wire logic pin,
  output logic sclk,
  output logic rd_wr_sel,
  output logic h_oe,
  output logic h_d
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Serial transfers, 800 ns clock, idle high between frames
  // ----
  initial begin
    sclk = 1'b1;
    rd_wr_sel = 1'b0;
    h_oe = 1'b0;
    h_d = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] b);
    rd_wr_sel = 1'b0;
    h_oe = 1'b1;
    half();
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      h_d = b[i];
      half();
      sclk = 1'b1;
      half();
    end
    h_oe = 1'b0;
    half();
  endtask
  task automatic rd(output logic [9:0] v);
    rd_wr_sel = 1'b1;
    half();
    v[9] = pin;
    for (int i = 8; i >= 0; i--) begin
      sclk = 1'b0;
      half();
      sclk = 1'b1;
      half();
      v[i] = pin;
    end
    rd_wr_sel = 1'b0;
    half();
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for tac_top with the host model on its serial port.
// Assumes tac_pkg constants; the converter code is fed on sample_code.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tac_pkg::*;
  logic clk, rst_n, cs_n, pin, pin_q, h_oe, h_d, sclk, rw, dout, oe, al_n, th, pd, act;
  logic [CHAN_W-1:0] ch;
  logic [BYTE_W-1:0] thr;
  logic [RESULT_W-1:0] res, code, v;
  int n_errors, num_checks, n;
  // Undriven pin toggles every cycle so a stale value never passes
  assign pin = oe ? dout : (h_oe ? h_d : ~pin_q);
  // Unknown folds to 0 so the toggle starts even before the first write
  always @(posedge clk) pin_q <= (pin === 1'b1);
  tac_top i_dut (.clk(clk), .rst_n(rst_n), .convert_start_n(cs_n), .sclk(sclk), .rd_wr_sel(rw),
    .data_in(pin), .data_out(dout), .data_oe(oe), .over_temp_alarm_n(al_n), .track_hold(th),
    .power_down(pd), .conv_active(act), .channel_addr(ch), .alarm_threshold_reg(thr),
    .conv_result(res), .sample_code(code));
  tac_host i_host (.clk(clk), .pin(pin), .sclk(sclk), .rd_wr_sel(rw), .h_oe(h_oe), .h_d(h_d));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conv(input logic lvl);
    cs_n = 1'b0;
    for (int i = 0; i < 20 && act !== 1'b1; i++) @(negedge clk);
    chk("hold", 10'h1, 10'(th));
    // Start is taken once busy shows; count from this first busy cycle
    cs_n = lvl;
    for (n = 0; n < 400 && act === 1'b1; n++) @(negedge clk);
    chk("track", 10'h0, 10'(th));
  endtask
  task automatic t_regs();
    logic [7:0] b [4];
    logic [7:0] et [4];
    logic [2:0] ec [4];
    b = '{8'hA0, 8'h07, 8'h08, 8'h00};
    et = '{8'hA0, 8'hA0, 8'h08, 8'h08};
    ec = '{3'h0, 3'h7, 3'h7, 3'h0};
    chk("thr_rst", 10'(THRESH_RESET), 10'(thr));
    for (int i = 0; i < 4; i++) begin
      i_host.wr(b[i]);
      chk("thr", 10'(et[i]), 10'(thr));
      chk("chan", 10'(ec[i]), 10'(ch));
    end
    $display("t_regs done");
  endtask
  task automatic t_alarm();
    code = 10'h024;
    conv(1'b1);
    chk("len", 10'(CONV_TEMP_CYC), 10'(n));
    chk("alarm", 10'h0, 10'(al_n));
    chk("pd", 10'h0, 10'(pd));
    i_host.rd(v);
    chk("read", 10'h024, v);
    chk("alarm_rel", 10'h1, 10'(al_n));
    chk("oe", 10'h0, 10'(oe));
    code = 10'h020;
    conv(1'b1);
    chk("alarm_eq", 10'h1, 10'(al_n));
    $display("t_alarm done");
  endtask
  task automatic t_pd();
    i_host.wr(8'h01);
    code = 10'h3FF;
    conv(1'b0);
    chk("len_in", 10'(CONV_INPUT_CYC), 10'(n));
    chk("pd_on", 10'h1, 10'(pd));
    chk("alarm_in", 10'h1, 10'(al_n));
    chk("res", 10'h3FF, res);
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("pd_off", 10'h0, 10'(pd));
    $display("t_pd done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    cs_n = 1'b1;
    code = '0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_alarm();
    t_pd();
    stop_test();
  end
endmodule
bind tac_top tac_top_props i_props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .rd_wr_sel(rd_wr_sel),
  .data_out(data_out), .data_oe(data_oe), .over_temp_alarm_n(over_temp_alarm_n),
  .track_hold(track_hold), .power_down(power_down), .conv_active(conv_active),
  .channel_addr(channel_addr), .alarm_threshold_reg(alarm_threshold_reg),
  .conv_result(conv_result));
